// ===== core/spread_clock_pkg.sv
// Purpose: Shared constants for the spread-spectrum clock select logic.
// Assumes: ref_clk runs at 100 MHz; output clocks come from phase accumulators.
// Notes:   Output rates are scaled down by a model factor so that they fit
//          below the Nyquist limit of ref_clk.
`default_nettype none
package spread_clock_pkg;
	localparam int unsigned CLK_KHZ        = 100000;
	localparam int unsigned REF_KHZ        = 14318;
	localparam int unsigned USB_KHZ        = 48000;
	localparam int unsigned STRAP_WAIT_MS  = 2;
	localparam int unsigned STRAP_WAIT_CYC = STRAP_WAIT_MS * (CLK_KHZ);
	localparam int unsigned ACC_W          = 32;
	localparam int unsigned DEPTH_DIV      = 10000;
	localparam logic [8:0]  DEPTH_LOW_BP   = 9'h07D;
	localparam logic [8:0]  DEPTH_HIGH_BP  = 9'h177;
	localparam logic [3:0]  ADDR_CTRL      = 4'h0;
	localparam logic [3:0]  ADDR_STATUS    = 4'h4;
	localparam int unsigned CTRL_FORCE_OFF = 0;
	localparam int unsigned ST_RUN         = 0;
	localparam int unsigned ST_DEPTH       = 1;
	localparam int unsigned ST_SPREAD      = 2;
	localparam int unsigned ST_TEST        = 3;
	localparam int unsigned ST_RATE_LSB    = 4;

	typedef enum logic [1:0]
	{
		STRAP_WAIT = 2'b00,
		RUNNING    = 2'b01
	} strap_state_t;

	// Nominal system clock rate in kHz for each select code.
	function automatic int unsigned rateKhz(input logic [3:0] sel);
		int unsigned khz;
		khz = 133300;
		case (sel)
			4'h0: khz = 133300;
			4'h1: khz = 120000;
			4'h2: khz = 100000;
			4'h3: khz = 74770;
			4'h4: khz = 70000;
			4'h5: khz = 66600;
			4'h6: khz = 60000;
			4'h7: khz = 50000;
			4'h8: khz = 40000;
			4'h9: khz = 33330;
			4'hA: khz = 30000;
			4'hB: khz = 25000;
			4'hC: khz = 20000;
			4'hD: khz = 16670;
			4'hE: khz = 12000;
			default: khz = 10000;
		endcase
		return khz;
	endfunction : rateKhz

	// Accumulator step that toggles an output at khz divided by scale.
	function automatic logic [ACC_W-1:0] stepFor(input int unsigned khz,
		input int unsigned scale);
		logic [63:0] num;
		num = 64'(khz) << (ACC_W + 1);
		return ACC_W'(num / (64'(scale) * 64'(CLK_KHZ)));
	endfunction : stepFor
endpackage : spread_clock_pkg
`default_nettype wire

// ===== core/phase_toggle_gen.sv
// Purpose: Phase accumulator whose carry toggles a registered clock output.
// Assumes: step is below half of the accumulator range.
// Notes:   The accumulator only advances when advance is high.
`default_nettype none
module phase_toggle_gen #(
	parameter int unsigned W = 32
) (
	input  wire logic         ref_clk,
	input  wire logic         srst,
	input  wire logic         advance,
	input  wire logic [W-1:0] step,
	output var  logic         clkOut
);
	logic [W-1:0] acc_r;
	logic [W-1:0] acc_nxt;
	logic         clk_r;
	logic         clk_nxt;
	logic [W:0]   sum;

	// Add the step and flip the output on each carry.
	always_comb
	begin
		sum     = {1'b0, acc_r} + {1'b0, step};
		acc_nxt = acc_r;
		clk_nxt = clk_r;
		if (advance)
		begin
			acc_nxt = sum[W-1:0];
			clk_nxt = clk_r ^ sum[W];
		end
	end

	// Register the accumulator and the output level.
	always_ff @(posedge ref_clk)
	begin
		if (srst)
		begin
			acc_r <= '0;
			clk_r <= 1'b0;
		end
		else
		begin
			acc_r <= acc_nxt;
			clk_r <= clk_nxt;
		end
	end

	assign clkOut = clk_r;
endmodule : phase_toggle_gen
`default_nettype wire

// ===== core/spread_clock_select.sv
// Purpose: Select, strap and spread control for a spread-spectrum clock
//          generator, with an Avalon-MM control and status port.
// Assumes: All pins are synchronous to ref_clk; srst stands for power-on.
// Notes:   Clock outputs are modelled at rate divided by RATE_SCALE.
// Function
// - The four-bit rate select picks one of sixteen system clock rates.
// - Spread depth is down 1.25 percent with the strap low, 3.75 if high.
// - Spread enable low modulates the system clock, high leaves it running unmodulated.
// - An undriven spread enable input reads low, so spreading is on.
// - The shared pin as input selects depth, used only while spreading.
// - The shared pin as output carries a fixed unmodulated 48 MHz clock.
// - Test mode stops modulation, floats outputs, uses the test reference.
// - Every output rate is derived from the 100 MHz ref_clk, or from test reference edges in test mode.
// - Outputs float for 2 ms while straps are sampled, then are latched.
// - Latched straps hold until the next power cycle.
`default_nettype none
module spread_clock_select #(
	parameter int unsigned STRAP_WAIT = spread_clock_pkg::STRAP_WAIT_CYC,
	parameter int unsigned RATE_SCALE = 16,
	parameter int unsigned MOD_DIV    = 64,
	parameter int unsigned TRI_MAX    = 255
) (
	input  wire logic        ref_clk,
	input  wire logic        srst,
	input  wire logic [3:0]  rateSelect,
	input  wire logic        spreadEnableN,
	input  wire logic        spreadEnableNDriven,
	input  wire logic        depthStrapIn,
	input  wire logic        testMode,
	input  wire logic        testRefIn,
	output var  logic        spreadSystemClockOut,
	output var  logic        sysClkOe_n,
	output var  logic        fixed48mClockOut,
	output var  logic        usbClkOe_n,
	input  wire logic [3:0]  avs_address,
	input  wire logic        avs_read,
	input  wire logic        avs_write,
	input  wire logic [31:0] avs_writedata,
	output var  logic [31:0] avs_readdata,
	output var  logic        avs_waitrequest
);
	localparam int unsigned AW = spread_clock_pkg::ACC_W;

	spread_clock_pkg::strap_state_t state_r;
	spread_clock_pkg::strap_state_t state_nxt;
	logic [31:0]   wait_r;
	logic [31:0]   wait_nxt;
	logic          depth_r;
	logic          depth_nxt;
	logic [7:0]    tri_r;
	logic [7:0]    tri_nxt;
	logic          triUp_r;
	logic          triUp_nxt;
	logic [15:0]   modCnt_r;
	logic [15:0]   modCnt_nxt;
	logic [AW-1:0] sysStep_r;
	logic [AW-1:0] sysStep_nxt;
	logic          testRef_r;
	logic          forceOff_r;
	logic          forceOff_nxt;
	logic          wait_req_r;
	logic          wait_req_nxt;
	logic [31:0]   rdata_r;
	logic [31:0]   rdata_nxt;
	logic          sysOe_r;
	logic          usbOe_r;
	logic          spread_system_clock_out_r;
	logic          fixed_48m_clock_out_r;
	logic          spreadOn;
	logic          advance;
	logic          sysRaw;
	logic          usbRaw;
	logic [AW-1:0] nomStep;
	logic [8:0]    depthBp;
	logic [63:0]   cut;
	logic          floatNxt;

	// Strap sampling window and one-time latch of the depth strap.
	always_comb
	begin
		state_nxt = state_r;
		wait_nxt  = wait_r;
		depth_nxt = depth_r;
		case (state_r)
			spread_clock_pkg::STRAP_WAIT:
			begin
				if (wait_r >= STRAP_WAIT - 1)
				begin
					depth_nxt = depthStrapIn;
					state_nxt = spread_clock_pkg::RUNNING;
				end
				else
				begin
					wait_nxt = wait_r + 32'h00000001;
				end
			end
			spread_clock_pkg::RUNNING:
			begin
				state_nxt = spread_clock_pkg::RUNNING;
			end
			default:
			begin
				state_nxt = spread_clock_pkg::STRAP_WAIT;
			end
		endcase
	end

	// Spreading is on when enabled by pin and software and not under test.
	always_comb
	begin
		spreadOn = ~(spreadEnableNDriven & spreadEnableN);
		spreadOn = spreadOn & ~forceOff_r & ~testMode;
		depthBp  = depth_r ? spread_clock_pkg::DEPTH_HIGH_BP
			: spread_clock_pkg::DEPTH_LOW_BP;
		nomStep  = spread_clock_pkg::stepFor(
			spread_clock_pkg::rateKhz(rateSelect), RATE_SCALE);
	end

	// Triangle modulation profile stepped every MOD_DIV cycles.
	always_comb
	begin
		modCnt_nxt = modCnt_r + 16'h0001;
		tri_nxt    = tri_r;
		triUp_nxt  = triUp_r;
		if (!spreadOn)
		begin
			modCnt_nxt = 16'h0000;
			tri_nxt    = 8'h00;
			triUp_nxt  = 1'b1;
		end
		else if (modCnt_r >= 16'(MOD_DIV - 1))
		begin
			modCnt_nxt = 16'h0000;
			if (triUp_r)
			begin
				tri_nxt   = tri_r + 8'h01;
				triUp_nxt = (tri_r + 8'h01) < 8'(TRI_MAX);
			end
			else
			begin
				tri_nxt   = tri_r - 8'h01;
				triUp_nxt = (tri_r - 8'h01) == 8'h00;
			end
		end
	end

	// Down-spread step: nominal minus its depth share scaled by profile.
	always_comb
	begin
		cut = (64'(nomStep) * 64'(depthBp) * 64'(tri_r))
			/ (64'(spread_clock_pkg::DEPTH_DIV) * 64'(TRI_MAX));
		sysStep_nxt = nomStep;
		if (spreadOn)
		begin
			sysStep_nxt = nomStep - AW'(cut);
		end
	end

	// In test mode the generators advance only on test reference edges.
	assign advance = testMode ? (testRefIn & ~testRef_r)
		: 1'b1;

	// Pins float until the straps are latched, and in test mode.
	assign floatNxt = (state_nxt != spread_clock_pkg::RUNNING)
		| testMode;

	// Avalon-MM slave: one wait cycle, then the answer for one cycle.
	always_comb
	begin
		wait_req_nxt = 1'b1;
		forceOff_nxt = forceOff_r;
		rdata_nxt    = rdata_r;
		if ((avs_read || avs_write) && wait_req_r)
		begin
			wait_req_nxt = 1'b0;
			if (avs_write && avs_address == spread_clock_pkg::ADDR_CTRL)
			begin
				forceOff_nxt = avs_writedata[spread_clock_pkg::CTRL_FORCE_OFF];
			end
			rdata_nxt = 32'h00000000;
			if (avs_read && avs_address == spread_clock_pkg::ADDR_CTRL)
			begin
				rdata_nxt[spread_clock_pkg::CTRL_FORCE_OFF] = forceOff_r;
			end
			else if (avs_read && avs_address == spread_clock_pkg::ADDR_STATUS)
			begin
				rdata_nxt[spread_clock_pkg::ST_RUN] =
					(state_r == spread_clock_pkg::RUNNING);
				rdata_nxt[spread_clock_pkg::ST_DEPTH]  = depth_r;
				rdata_nxt[spread_clock_pkg::ST_SPREAD] = spreadOn;
				rdata_nxt[spread_clock_pkg::ST_TEST]   = testMode;
				rdata_nxt[spread_clock_pkg::ST_RATE_LSB +: 4] = rateSelect;
			end
		end
	end

	// System clock generator, its step tracking the spread profile.
	phase_toggle_gen #(
		.W       (AW)
	) sysGen (
		.ref_clk (ref_clk),
		.srst    (srst),
		.advance (advance),
		.step    (sysStep_r),
		.clkOut  (sysRaw)
	);

	// Fixed 48 MHz generator, never modulated.
	phase_toggle_gen #(
		.W       (AW)
	) usbGen (
		.ref_clk (ref_clk),
		.srst    (srst),
		.advance (advance),
		.step    (spread_clock_pkg::stepFor(spread_clock_pkg::USB_KHZ,
			RATE_SCALE)),
		.clkOut  (usbRaw)
	);

	// Register all state; outputs float while sampling and under test.
	always_ff @(posedge ref_clk)
	begin
		if (srst)
		begin
			state_r    <= spread_clock_pkg::STRAP_WAIT;
			wait_r     <= 32'h00000000;
			depth_r    <= 1'b0;
			tri_r      <= 8'h00;
			triUp_r    <= 1'b1;
			modCnt_r   <= 16'h0000;
			sysStep_r  <= '0;
			testRef_r  <= 1'b0;
			forceOff_r <= 1'b0;
			wait_req_r <= 1'b1;
			rdata_r    <= 32'h00000000;
			sysOe_r    <= 1'b1;
			usbOe_r    <= 1'b1;
			spread_system_clock_out_r   <= 1'b0;
			fixed_48m_clock_out_r   <= 1'b0;
		end
		else
		begin
			state_r    <= state_nxt;
			wait_r     <= wait_nxt;
			depth_r    <= depth_nxt;
			tri_r      <= tri_nxt;
			triUp_r    <= triUp_nxt;
			modCnt_r   <= modCnt_nxt;
			sysStep_r  <= sysStep_nxt;
			testRef_r  <= testRefIn;
			forceOff_r <= forceOff_nxt;
			wait_req_r <= wait_req_nxt;
			rdata_r    <= rdata_nxt;
			sysOe_r    <= floatNxt;
			usbOe_r    <= floatNxt;
			spread_system_clock_out_r   <= sysRaw;
			fixed_48m_clock_out_r   <= usbRaw;
		end
	end

	assign spreadSystemClockOut = spread_system_clock_out_r;
	assign fixed48mClockOut     = fixed_48m_clock_out_r;
	assign sysClkOe_n           = sysOe_r;
	assign usbClkOe_n           = usbOe_r;
	assign avs_readdata         = rdata_r;
	assign avs_waitrequest      = wait_req_r;
endmodule : spread_clock_select
`default_nettype wire

// ===== verification/spread_clock_select_asserts.sv
// Purpose: Bus, strap and output enable checks for the clock select block.
// Assumes: The strap pin is steady through the whole strap window.
// Notes:   The cycle count since reset saturates at 255.
`default_nettype none
module spread_clock_select_asserts #(
	parameter int unsigned STRAP_WAIT = 20
) (
	input wire logic        ref_clk,
	input wire logic        srst,
	input wire logic [3:0]  rateSelect,
	input wire logic        depthStrapIn,
	input wire logic        testMode,
	input wire logic        sysClkOe_n,
	input wire logic        usbClkOe_n,
	input wire logic [3:0]  avs_address,
	input wire logic        avs_read,
	input wire logic        avs_write,
	input wire logic [31:0] avs_readdata,
	input wire logic        avs_waitrequest
);
	logic [7:0] age_r;
	logic [7:0] age_nxt;
	logic       strap_r;
	logic       strap_nxt;
	// Cycles since reset, and the strap level seen inside the window.
	always_comb
	begin
		age_nxt = srst ? 8'h00 : age_r + 8'(age_r != 8'hFF);
		strap_nxt = (age_r == 8'(STRAP_WAIT / 2)) ? depthStrapIn : strap_r;
	end
	always_ff @(posedge ref_clk)
	begin
		age_r <= age_nxt;
		strap_r <= strap_nxt;
	end
	default clocking @(posedge ref_clk); endclocking
	default disable iff (srst);
	// A status answer, one cycle after the read was taken.
	sequence stRead;
		!avs_waitrequest && $past(avs_read)
			&& $past(avs_address) == spread_clock_pkg::ADDR_STATUS;
	endsequence
	a_float_window: assert property (age_r < STRAP_WAIT |->
		sysClkOe_n && usbClkOe_n) else $error("pins driven in strap window");
	a_drive_after: assert property (age_r == STRAP_WAIT && !testMode
		|-> !sysClkOe_n && !usbClkOe_n) else $error("pins not enabled");
	a_test_float: assert property (testMode [*3] |->
		sysClkOe_n && usbClkOe_n) else $error("pins driven in test mode");
	a_answer_next: assert property ((avs_read || avs_write)
		&& avs_waitrequest |=> !avs_waitrequest) else $error("late answer");
	a_answer_once: assert property (!avs_waitrequest |=> avs_waitrequest)
		else $error("waitrequest low twice");
	a_idle_wait: assert property (!avs_read && !avs_write |=> avs_waitrequest)
		else $error("answer without request");
	a_unmapped_zero: assert property (!avs_waitrequest && $past(avs_read)
		&& $past(avs_address) > 4'h4 |-> avs_readdata == 32'h0)
		else $error("unmapped read not zero");
	a_strap_kept: assert property (stRead ##0 (age_r > STRAP_WAIT + 2) |->
		avs_readdata[spread_clock_pkg::ST_DEPTH] == strap_r)
		else $error("latched depth lost");
	a_rate_echo: assert property (stRead |->
		avs_readdata[spread_clock_pkg::ST_RATE_LSB +: 4]
			== $past(rateSelect))
		else $error("rate code not reported");
	cover property (!avs_waitrequest && $past(avs_write));
	cover property (testMode && sysClkOe_n);
	cover property (age_r == STRAP_WAIT + 2 && !usbClkOe_n);
endmodule : spread_clock_select_asserts
bind spread_clock_select spread_clock_select_asserts #(
	.STRAP_WAIT(STRAP_WAIT)
) chk_inst (.ref_clk, .srst, .rateSelect, .depthStrapIn, .testMode,
	.sysClkOe_n, .usbClkOe_n, .avs_address, .avs_read, .avs_write,
	.avs_readdata, .avs_waitrequest);
`default_nettype wire

// ===== verification/clock_consumer.sv
// Purpose: Far side: strap resistor on the shared pin and clock consumers.
// Assumes: Counts are cleared before each measuring window.
// Notes:   Edges are only counted while the pin is driven.
`default_nettype none
module clock_consumer (
	input  wire logic        ref_clk,
	input  wire logic        clear,
	input  wire logic        strapLevel,
	input  wire logic        spread_system_clock_out,
	input  wire logic        sysOe_n,
	input  wire logic        fixed_48m_clock_out,
	input  wire logic        usbOe_n,
	output var  logic        pinLevel,
	output var  logic [15:0] sysEdges,
	output var  logic [15:0] usbEdges
);
	timeunit 1ns;
	timeprecision 1ps;
	logic sysLast;
	logic usbLast;
	// The resistor sets the pin while floated, the device clock after.
	assign pinLevel = usbOe_n ? strapLevel : fixed_48m_clock_out;
	// Rising edges of each clock as the consumer logic sees them.
	always @(posedge ref_clk)
	begin
		sysLast <= spread_system_clock_out;
		usbLast <= fixed_48m_clock_out;
		sysEdges <= clear ? 16'h0
			: sysEdges + 16'(spread_system_clock_out && !sysLast && !sysOe_n);
		usbEdges <= clear ? 16'h0
			: usbEdges + 16'(fixed_48m_clock_out && !usbLast && !usbOe_n);
	end
endmodule : clock_consumer
`default_nettype wire

// ===== verification/spread_clock_select_bench.sv
// Purpose: Self-checking bench for the clock select block.
// Assumes: Short strap window and fast spread triangle parameters.
// Notes:   Clock rates are judged by edge counts over a fixed window.
`default_nettype none
module spread_clock_select_bench;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int unsigned WAIT = 20;
	localparam int unsigned WIN = 3000;
	localparam int unsigned KHZ [16] = '{133300, 120000, 100000, 74770,
		70000, 66600, 60000, 50000, 40000, 33330, 30000, 25000, 20000,
		16670, 12000, 10000};
	logic ref_clk = 1'b0, srst = 1'b1, spreadEnableN = 1'b1;
	logic spreadEnableNDriven = 1'b1, testMode = 1'b0;
	logic testRef = 1'b0;
	int tog;
	logic strapLevel = 1'b1, clear = 1'b1, avs_read = 1'b0, avs_write = 1'b0;
	logic [3:0] rateSelect = 4'h0, avs_address = 4'h0;
	logic [31:0] avs_writedata = 32'h0, avs_readdata, q;
	logic pin, spread_system_clock_out, sysOe_n, fixed_48m_clock_out, usbOe_n, avs_waitrequest;
	logic [15:0] sysEdges, usbEdges;
	int n_mismatch = 0, num_checks = 0, cycles = 0, nom;
	spread_clock_select #(.STRAP_WAIT(WAIT), .RATE_SCALE(16), .MOD_DIV(2),
		.TRI_MAX(4)) spread_clock_select_inst (.ref_clk, .srst, .rateSelect,
		.spreadEnableN, .spreadEnableNDriven, .depthStrapIn(pin),
		.testMode, .testRefIn(testRef), .spreadSystemClockOut(spread_system_clock_out),
		.sysClkOe_n(sysOe_n), .fixed48mClockOut(fixed_48m_clock_out),
		.usbClkOe_n(usbOe_n),
		.avs_address, .avs_read, .avs_write, .avs_writedata, .avs_readdata,
		.avs_waitrequest);
	clock_consumer clock_consumer_inst (.ref_clk, .clear, .strapLevel,
		.spread_system_clock_out, .sysOe_n, .fixed_48m_clock_out, .usbOe_n, .pinLevel(pin), .sysEdges,
		.usbEdges);
	// The 100 MHz clock.
	initial
		forever #5 ref_clk = ~ref_clk;
	task automatic summarize();
		$display("checks %0d mismatches %0d", num_checks, n_mismatch);
		if (n_mismatch == 0 && num_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : summarize
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp)
		begin
			n_mismatch++;
			$display("unexpected at %0t: seen %0h expected %0h",
				$time, seen, exp);
		end
	endtask : check
	// One Avalon transfer, held until waitrequest is sampled low.
	task automatic xfer(input logic wr, input logic [3:0] a,
		input logic [31:0] d);
		@(posedge ref_clk);
		avs_write <= wr;
		avs_read <= !wr;
		avs_address <= a;
		avs_writedata <= d;
		do @(posedge ref_clk); while (avs_waitrequest !== 1'b0);
		q = avs_readdata;
		avs_write <= 1'b0;
		avs_read <= 1'b0;
	endtask : xfer
	task automatic st(input logic [7:0] exp, input logic [7:0] mask);
		xfer(1'b0, spread_clock_pkg::ADDR_STATUS, 32'h0);
		check(q[7:0] & mask, exp & mask);
	endtask : st
	// Counts edges over the window; nom is the unspread system count.
	task automatic measure(input int r);
		clear <= 1'b1;
		@(posedge ref_clk);
		clear <= 1'b0;
		repeat (WIN) @(posedge ref_clk);
		nom = WIN * KHZ[r] / 1600000;
		check(usbEdges <= 91 && usbEdges >= 89, 1);
	endtask : measure
	// Cuts a hang short.
	always @(posedge ref_clk)
	begin
		cycles++;
		if (cycles == 80000)
		begin
			n_mismatch++;
			summarize();
		end
	end
	initial
	begin
		repeat (16) @(posedge ref_clk);
		srst <= 1'b0;
		repeat (2) @(posedge ref_clk);
		check({usbOe_n, sysOe_n}, 2'b11);
		repeat (WAIT + 4) @(posedge ref_clk);
		check({usbOe_n, sysOe_n}, 2'b00);
		st(8'h03, 8'hFF);
		xfer(1'b1, 4'h8, 32'hFFFFFFFF);
		xfer(1'b0, 4'h8, 32'h0);
		check(q, 32'h0);
		xfer(1'b0, spread_clock_pkg::ADDR_CTRL, 32'h0);
		check(q, 32'h0);
		spreadEnableN <= 1'b0;
		st(8'h07, 8'hFF);
		xfer(1'b1, spread_clock_pkg::ADDR_CTRL, 32'h1);
		st(8'h03, 8'hFF);
		xfer(1'b1, spread_clock_pkg::ADDR_CTRL, 32'h0);
		spreadEnableN <= 1'b1;
		spreadEnableNDriven <= 1'b0;
		st(8'h07, 8'hFF);
		measure(0);
		check(sysEdges < nom - 1 && sysEdges > nom - 9, 1);
		spreadEnableNDriven <= 1'b1;
		for (int r = 0; r < 16; r++)
		begin
			rateSelect <= 4'(r);
			repeat (4) @(posedge ref_clk);
			measure(r);
			check(sysEdges <= nom + 1 && sysEdges + 1 >= nom, 1);
			st({4'(r), 4'h3}, 8'hFF);
		end
		testMode <= 1'b1;
		repeat (4) @(posedge ref_clk);
		check({usbOe_n, sysOe_n}, 2'b11);
		st(8'h0A, 8'h0E);
		// Without test reference edges both generators stand still.
		q = {30'h0, fixed_48m_clock_out, spread_system_clock_out};
		repeat (40) @(posedge ref_clk);
		check({fixed_48m_clock_out, spread_system_clock_out}, q[1:0]);
		// A hundred test reference edges advance the 48 MHz model.
		tog = 0;
		repeat (200)
		begin
			@(posedge ref_clk);
			testRef <= !testRef;
			tog += int'(fixed_48m_clock_out != q[1]);
			q[1] = fixed_48m_clock_out;
		end
		check(tog >= 4 && tog <= 7, 1);
		testMode <= 1'b0;
		strapLevel <= 1'b0;
		srst <= 1'b1;
		repeat (4) @(posedge ref_clk);
		srst <= 1'b0;
		repeat (WAIT + 4) @(posedge ref_clk);
		st(8'hF1, 8'hFF);
		// Low strap: the shallow spread loses well under one percent.
		spreadEnableN <= 1'b0;
		rateSelect <= 4'h0;
		repeat (4) @(posedge ref_clk);
		measure(0);
		check(sysEdges + 2 >= nom && sysEdges <= nom, 1);
		summarize();
	end
endmodule : spread_clock_select_bench
`default_nettype wire
